// file: hdl/rate_div.sv
// Half-period tick generator for the master serial clock.
// Assumes restart is held while no transfer runs.

`timescale 1ns/100ps
`default_nettype none

module rate_div (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control
	input wire logic restart,
	input wire logic [2:0] rate,
	// Tick
	output logic tick
);
	import spi_pkg::*;

	logic [6:0] cnt_q;
	logic tick_q;

	// Invalid codes fall back to the slowest rate rather than stalling.
	wire logic bad_rate = (rate == 3'h0) || (rate == 3'h7);
	wire logic [2:0] rate_ok = bad_rate ? RATE_SLOWEST : rate;
	wire logic [6:0] half = 7'h01 << rate_ok;
	wire logic at_end = (cnt_q == half - 7'h01);

	always_ff @(posedge clk) begin
		if (srst || restart || at_end) begin
			cnt_q <= 7'h00;
		end else begin
			cnt_q <= cnt_q + 7'h01;
		end
	end

	always_ff @(posedge clk) begin
		tick_q <= !srst && !restart && at_end;
	end

	assign tick = tick_q;

endmodule : rate_div

`default_nettype wire

// file: hdl/spi_pkg.sv
// Shared constants and carrier types of the serial peripheral block.
// Assumes a byte-wide register port and a single peripheral clock.

package spi_pkg;

	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [7:0] CTRL_ADDR = 8'hc3;
	localparam logic [7:0] STAT_ADDR = 8'hc4;
	localparam logic [7:0] DATA_ADDR = 8'hc5;

	// ----------------------------------------
	// Status field positions
	// ----------------------------------------
	localparam int TC_BIT = 7;
	localparam int OVR_BIT = 5;
	localparam int MODE_FAULT_FLAG_BIT = 4;
	localparam int TE_BIT = 3;
	localparam int LSB_BIT = 2;
	localparam int TEIE_BIT = 1;
	localparam int MODE_FAULT_IRQ_ENABLE_BIT = 0;

	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h14;
	localparam logic [2:0] BITS_LAST = 3'h7;
	localparam logic [2:0] RATE_SLOWEST = 3'h6;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic rate_hi;
		logic enable;
		logic ss_disable;
		logic master;
		logic cpol;
		logic cpha;
		logic rate_mid;
		logic rate_lo;
	} ctrl_t;

	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic ss_n;
	} pins_t;

endpackage : spi_pkg

// file: hdl/spi_status_data.sv
// Status flags, bit order, interrupt request and data path of a byte-wide serial peripheral.
// Assumes a register port on clk and serial pins that are asynchronous to it.
//
// What this block does
// R1 - Set mode fault when slave select sits at a wrong level, master or slave.
// R2 - Reading the status register clears the mode fault flag.
// R3 - Slave after mode fault ignores data while select is high, resumes when low.
// R4 - Master mode fault clears the peripheral enable bit.
// R5 - Transmit empty flag is high while the shift register can take a byte.
// R6 - Software bit selects MSB first when clear, LSB first when set.
// R7 - With its enable set, transmit empty raises the interrupt.
// R8 - With transmit empty interrupts enabled, transfer complete raises no interrupt.
// R9 - With its enable set, mode fault raises the interrupt.
// R10 - A data write loads the shift register directly, no holding buffer.
// R11 - A data read returns the receive buffer, never the shift register.
// R12 - A data write during a transfer gives an overflow.
// R13 - Clearing enable mid transfer stops the peripheral at once.
// R14 - Software keeps rate, phase, polarity and master bits still during transfers.
// R15 - All registers may be read and written while idle.
// R16 - After reset status bits 7, 6 and 4 read as zero.
// R17 - Transfer complete sets on byte end, clears on status read then data access.
// R18 - Byte received while complete is set gives overrun, old byte kept.
// R19 - Clear enable resets the serial engine internally, set enables it.
// R20 - One interrupt request is the OR of the enabled sources.
//
// Design decision made here: the address-and-strobe port.

`timescale 1ns/100ps
`default_nettype none

module spi_status_data (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Serial clock
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	// Master out, slave in
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	// Master in, slave out
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	// Slave select
	input wire logic ss_n_in,
	// Interrupt
	output logic irq
);
	import spi_pkg::*;

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	pins_t pins_raw;
	pins_t pins_s;
	assign pins_raw = '{sck: sck_in, mosi: mosi_in, miso: miso_in, ss_n: ss_n_in};

	sync2 #(.W(4)) u_sync (
		.clk(clk),
		.srst(srst),
		.d(pins_raw),
		.q(pins_s)
	);

	// ----------------------------------------
	// State
	// ----------------------------------------
	ctrl_t ctrl_q;
	logic [7:0] sh_q;
	logic [7:0] rxbuf_q;
	logic [7:0] rdata_q;
	logic [2:0] cnt_q;
	logic busy_q;
	logic sclk_q;
	logic out_q;
	logic rx_bit_q;
	logic sck_prev_q;
	logic tc_q, arm_q, ovr_q, mode_fault_flag_q, te_q, lsb_q, teie_q, mode_fault_irq_enable_q;
	logic ignore_q, irq_q, sck_oe_q, miso_oe_q;
	logic tick;

	function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb);
		return lsb ? {b, v[7:1]} : {v[6:0], b};
	endfunction : shift_in

	function automatic logic top_bit(input logic [7:0] v, input logic lsb);
		return lsb ? v[0] : v[7];
	endfunction : top_bit

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	wire logic wr_ctrl = wr && (addr == CTRL_ADDR);
	wire logic wr_stat = wr && (addr == STAT_ADDR);
	wire logic wr_data = wr && (addr == DATA_ADDR);
	wire logic rd_stat = rd && (addr == STAT_ADDR);
	wire logic rd_data = rd && (addr == DATA_ADDR);

	wire logic en = ctrl_q.enable;
	wire logic master_select = ctrl_q.master;
	wire logic ss_low = !pins_s.ss_n;

	// ----------------------------------------
	// Edge decode
	// ----------------------------------------
	wire logic sel = en && !master_select && (ctrl_q.ss_disable || ss_low) && !ignore_q;
	wire logic s_edge = sel && (pins_s.sck != sck_prev_q);
	wire logic m_edge = en && master_select && busy_q && tick;
	wire logic lead = (m_edge && (sclk_q == ctrl_q.cpol)) || (s_edge && (pins_s.sck != ctrl_q.cpol));
	wire logic trail = (m_edge && (sclk_q != ctrl_q.cpol)) || (s_edge && (pins_s.sck == ctrl_q.cpol));
	wire logic din = master_select ? pins_s.miso : pins_s.mosi;
	wire logic [7:0] sh_nx = shift_in(sh_q, ctrl_q.cpha ? din : rx_bit_q, lsb_q); // see R6
	wire logic done = trail && (cnt_q == BITS_LAST) && busy_q;

	// A master sees another master driving select low; a slave loses select mid byte.
	wire logic m_fault = master_select && ss_low;
	wire logic s_fault = !master_select && busy_q && !ss_low;
	wire logic mode_fault_flag_set = en && !ctrl_q.ss_disable && (m_fault || s_fault); // see R1
	wire logic abort = !en || mode_fault_flag_set; // see R13 see R19
	wire logic load = wr_data && en && !busy_q; // see R15
	wire logic coll = wr_data && busy_q; // see R12
	wire logic clr_tc = arm_q && (rd_data || wr_data);

	// ----------------------------------------
	// Master clock divider
	// ----------------------------------------
	rate_div u_div (
		.clk(clk),
		.srst(srst),
		.restart(!busy_q || !master_select),
		.rate({ctrl_q.rate_hi, ctrl_q.rate_mid, ctrl_q.rate_lo}),
		.tick(tick)
	);

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= ctrl_t'(CTRL_RESET);
		end else if (mode_fault_flag_set && master_select) begin
			ctrl_q.enable <= 1'b0; // see R4
		end else if (wr_ctrl) begin
			ctrl_q <= ctrl_t'(wdata);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			lsb_q <= 1'b0;
			teie_q <= 1'b0;
			mode_fault_irq_enable_q <= 1'b0;
		end else if (wr_stat) begin
			lsb_q <= wdata[LSB_BIT]; // see R6
			teie_q <= wdata[TEIE_BIT];
			mode_fault_irq_enable_q <= wdata[MODE_FAULT_IRQ_ENABLE_BIT];
		end
	end

	// ----------------------------------------
	// Shift engine
	// ----------------------------------------
	always_ff @(posedge clk) begin
		sck_prev_q <= pins_s.sck;
		if (srst || abort) begin
			busy_q <= 1'b0;
			cnt_q <= 3'h0;
		end else if (load) begin
			busy_q <= master_select;
			cnt_q <= 3'h0;
		end else if (done) begin
			busy_q <= 1'b0;
			cnt_q <= 3'h0;
		end else begin
			busy_q <= busy_q || lead;
			cnt_q <= trail ? cnt_q + 3'h1 : cnt_q;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sh_q <= 8'h00;
			out_q <= 1'b0;
			rx_bit_q <= 1'b0;
		end else if (load) begin
			sh_q <= wdata; // see R10
			out_q <= top_bit(wdata, lsb_q);
		end else if (!abort) begin
			if (lead) begin
				rx_bit_q <= din;
			end
			if (lead && ctrl_q.cpha) begin
				out_q <= top_bit(sh_q, lsb_q);
			end
			if (trail) begin
				sh_q <= sh_nx;
			end
			if (trail && !ctrl_q.cpha) begin
				out_q <= top_bit(sh_nx, lsb_q);
			end
		end
	end

	// The master clock parks at the idle level whenever no byte is moving.
	always_ff @(posedge clk) begin
		if (srst) begin
			sclk_q <= 1'b0;
		end else if (abort || !busy_q) begin
			sclk_q <= ctrl_q.cpol;
		end else if (m_edge) begin
			sclk_q <= !sclk_q;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ignore_q <= 1'b0;
		end else if (mode_fault_flag_set && !master_select) begin
			ignore_q <= 1'b1; // see R3
		end else if (ss_low || master_select || !en) begin
			ignore_q <= 1'b0; // see R3
		end
	end

	// ----------------------------------------
	// Flags and receive buffer
	// ----------------------------------------
	// Every hardware set below wins over a clear in the same cycle.
	always_ff @(posedge clk) begin
		if (srst) begin
			tc_q <= 1'b0;
			arm_q <= 1'b0;
			ovr_q <= 1'b0;
			mode_fault_flag_q <= 1'b0;
			te_q <= 1'b1;
		end else begin
			tc_q <= done || (tc_q && !clr_tc); // see R17
			arm_q <= rd_stat || (arm_q && !(rd_data || wr_data)); // see R17
			ovr_q <= (done && tc_q) || coll || (ovr_q && !rd_stat); // see R18 see R12
			mode_fault_flag_q <= mode_fault_flag_set || (mode_fault_flag_q && !rd_stat); // see R1 see R2
			te_q <= (abort || done) ? 1'b1 : (load ? 1'b0 : te_q); // see R5
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rxbuf_q <= 8'h00;
		end else if (done && !tc_q) begin
			rxbuf_q <= sh_nx; // see R18
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	wire logic [7:0] stat_rd = {tc_q, 1'b0, ovr_q, mode_fault_flag_q, te_q, lsb_q, teie_q, mode_fault_irq_enable_q}; // see R16
	wire logic [7:0] rd_mux = (addr == CTRL_ADDR) ? ctrl_q :
		(addr == STAT_ADDR) ? stat_rd :
		(addr == DATA_ADDR) ? rxbuf_q : 8'h00; // see R11

	always_ff @(posedge clk) begin
		if (srst || !rd) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rd_mux;
		end
	end

	// ----------------------------------------
	// Interrupt and pins
	// ----------------------------------------
	// Transfer complete is masked while transmit empty interrupts are on.
	wire logic irq_d = (teie_q && te_q) || (!teie_q && tc_q) || (mode_fault_irq_enable_q && mode_fault_flag_q); // see R7 see R8 see R9 see R20

	always_ff @(posedge clk) begin
		if (srst) begin
			irq_q <= 1'b0;
			sck_oe_q <= 1'b0;
			miso_oe_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
			sck_oe_q <= en && master_select;
			miso_oe_q <= sel && !mode_fault_flag_set;
		end
	end

	assign rdata = rdata_q;
	assign irq = irq_q;
	assign sck_out = sclk_q;
	assign sck_oe = sck_oe_q;
	assign mosi_out = out_q;
	assign mosi_oe = sck_oe_q;
	assign miso_out = out_q;
	assign miso_oe = miso_oe_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	// A shift edge may legally fall in the cycle of a refused write, so that case is left out.
	sequence s_idle_two; !busy_q ##1 !busy_q; endsequence
	property p_master_fault; (en && master_select && !ctrl_q.ss_disable && ss_low) |=> mode_fault_flag_q && !en; endproperty
	a_master_fault: assert property (p_master_fault) else $error("master fault not flagged"); // see R1 see R4
	property p_mode_fault_flag_clear; (rd_stat && !mode_fault_flag_set) |=> !mode_fault_flag_q; endproperty
	a_mode_fault_flag_clear: assert property (p_mode_fault_flag_clear) else $error("mode fault not cleared"); // see R2
	property p_ignore; ignore_q |-> !busy_q; endproperty
	a_ignore: assert property (p_ignore) else $error("slave busy while ignoring"); // see R3
	property p_te_load; (load && !mode_fault_flag_set) |=> !te_q && busy_q == $past(master_select); endproperty
	a_te_load: assert property (p_te_load) else $error("empty flag stays high after load"); // see R5
	property p_load_bit;
		(load && !mode_fault_flag_set) |=> out_q == (lsb_q ? $past(wdata[0]) : $past(wdata[7]));
	endproperty
	a_load_bit: assert property (p_load_bit) else $error("first bit order wrong"); // see R6 see R10
	property p_tc_mask; (teie_q && !te_q && !(mode_fault_irq_enable_q && mode_fault_flag_q)) |=> !irq_q; endproperty
	a_tc_mask: assert property (p_tc_mask) else $error("complete irq not masked"); // see R8
	property p_rd_data; rd_data |=> rdata == $past(rxbuf_q); endproperty
	a_rd_data: assert property (p_rd_data) else $error("data read not from buffer"); // see R11
	property p_collide; (coll && !trail) |=> ovr_q && $stable(sh_q); endproperty
	a_collide: assert property (p_collide) else $error("write during transfer not refused"); // see R12
	property p_stop; (!en && !wr_ctrl) |=> s_idle_two; endproperty
	a_stop: assert property (p_stop) else $error("busy after disable"); // see R13
	property p_overrun; (done && tc_q) |=> ovr_q && $stable(rxbuf_q); endproperty
	a_overrun: assert property (p_overrun) else $error("overrun lost or buffer overwritten"); // see R18

endmodule : spi_status_data

`default_nettype wire

// file: hdl/sync2.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk.

`timescale 1ns/100ps
`default_nettype none

module sync2 #(
	parameter int W = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;

endmodule : sync2

`default_nettype wire

// file: verification/spi_far_model.sv
// External slave device model for master mode transfers, clock mode 0.
// Assumes the bench selects it around each byte and resolves the shared lines.

`timescale 1ns/100ps
`default_nettype none

module spi_far_model (
	// Serial lines
	input wire logic sck,
	input wire logic mosi,
	input wire logic sel,
	output logic miso,
	// Byte exchange
	input wire logic [7:0] load,
	output logic [7:0] got
);
	logic [7:0] sh = 8'h00;
	initial got = 8'h00;
	// ----------------------------------------
	// Shifting
	// ----------------------------------------
	always @(posedge sel) sh = load;
	always @(posedge sck) if (sel) got = {got[6:0], mosi};
	always @(negedge sck) if (sel) sh = {sh[6:0], ~sh[7]};
	// A released line shows the inverse of the last bit, so a stale level cannot pass.
	assign miso = sel ? sh[7] : ~sh[7];
endmodule : spi_far_model

`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the serial status and data block.
// Assumes the far-side slave model and the design files are compiled first.

`timescale 1ns/100ps
`default_nettype none

module testbench;
	import spi_pkg::*;
	typedef struct packed {logic [7:0] e; logic [7:0] m;} note_t;
	logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, ss_n = 1'b1, sel = 1'b0, flt = 1'b0, pend = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, lp = 8'h00, got, da, pa, kept = 8'h00;
	logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, miso_m, irq;
	wire logic sck_l, mosi_l, miso_l;
	int mismatches = 0, compares = 0, cyc = 0;
	logic [31:0] rnd = 32'h2228;
	note_t notes[$];
	note_t n;
	// ----------------------------------------
	// Clock, lines and instances
	// ----------------------------------------
	always #2.5 clk = ~clk;
	// Undriven lines toggle every cycle so that no leftover level is mistaken for data.
	always @(posedge clk) flt <= ~flt;
	assign sck_l = sck_oe ? sck_out : flt;
	assign mosi_l = mosi_oe ? mosi_out : flt;
	assign miso_l = miso_oe ? miso_out : miso_m;
	spi_status_data dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .sck_in(sck_l), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_l),
		.mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_l), .miso_out(miso_out),
		.miso_oe(miso_oe), .ss_n_in(ss_n), .irq(irq));
	spi_far_model far (.sck(sck_l), .mosi(mosi_l), .sel(sel), .miso(miso_m), .load(lp), .got(got));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	function automatic logic [7:0] rev(input logic [7:0] x);
		return {x[0], x[1], x[2], x[3], x[4], x[5], x[6], x[7]};
	endfunction : rev
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		notes.push_back('{e: e & m, m: m});
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask : rd_reg
	// Control stays untouched while a byte runs; only the optional second data write intrudes.
	task automatic xfer(input logic [7:0] d, input logic [7:0] p, input logic irq_e, input logic extra);
		lp <= p;
		sel <= 1'b1;
		wr_reg(DATA_ADDR, d);
		repeat (20) @(posedge clk);
		check("irq mid byte", {7'h00, irq}, {7'h00, irq_e});
		if (extra) wr_reg(DATA_ADDR, ~d);
		// A byte at the bench rate takes sixteen half periods of sixteen clocks.
		repeat (260) @(posedge clk);
		sel <= 1'b0;
		check("link pins after byte", {5'h00, sck_oe, mosi_oe, sck_out}, 8'h06);
	endtask : xfer
	function automatic void roll();
		rnd = lfsr(rnd);
		da = rnd[7:0];
		rnd = lfsr(rnd);
		pa = rnd[7:0];
	endfunction : roll
	// ----------------------------------------
	// Read result monitor and timeout
	// ----------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			mismatches++;
			finish_test();
		end else begin
			if (pend && notes.size() == 0) begin
				check("unexpected read", 8'h00, 8'hff);
			end else if (pend) begin
				n = notes.pop_front();
				check("read data", rdata & n.m, n.e);
			end
			pend = rd;
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		rd_reg(CTRL_ADDR, CTRL_RESET, 8'hff);
		rd_reg(STAT_ADDR, 8'h08, 8'hff);
		rd_reg(8'h00, 8'h00, 8'hff);
		wr_reg(CTRL_ADDR, 8'hf0);
		rd_reg(CTRL_ADDR, 8'hf0, 8'hff);
		wr_reg(STAT_ADDR, 8'hff);
		rd_reg(STAT_ADDR, 8'h0f, 8'hff);
		wr_reg(STAT_ADDR, 8'h00);
		$display("test registers done");
		roll();
		xfer(da, pa, 1'b0, 1'b0);
		check("far got msb first", got, da);
		rd_reg(STAT_ADDR, 8'h88, 8'hff);
		rd_reg(DATA_ADDR, pa, 8'hff);
		rd_reg(STAT_ADDR, 8'h08, 8'hff);
		wr_reg(STAT_ADDR, 8'h04);
		roll();
		xfer(da, pa, 1'b0, 1'b0);
		check("far got lsb first", got, rev(da));
		rd_reg(STAT_ADDR, 8'h8c, 8'hff);
		rd_reg(DATA_ADDR, rev(pa), 8'hff);
		wr_reg(STAT_ADDR, 8'h00);
		$display("test byte order done");
		roll();
		xfer(da, pa, 1'b0, 1'b0);
		kept = pa;
		roll();
		xfer(da, pa, 1'b1, 1'b0);
		wr_reg(STAT_ADDR, 8'h02);
		roll();
		xfer(da, pa, 1'b0, 1'b0);
		check("irq te enabled", {7'h00, irq}, 8'h01);
		rd_reg(STAT_ADDR, 8'haa, 8'hff);
		rd_reg(DATA_ADDR, kept, 8'hff);
		rd_reg(STAT_ADDR, 8'h0a, 8'hff);
		wr_reg(STAT_ADDR, 8'h00);
		repeat (2) @(posedge clk);
		check("irq all off", {7'h00, irq}, 8'h00);
		$display("test overrun done");
		roll();
		xfer(da, pa, 1'b0, 1'b1);
		check("far got first byte", got, da);
		rd_reg(STAT_ADDR, 8'ha8, 8'hff);
		rd_reg(DATA_ADDR, pa, 8'hff);
		sel <= 1'b1;
		wr_reg(DATA_ADDR, 8'h5a);
		repeat (20) @(posedge clk);
		wr_reg(CTRL_ADDR, 8'hb0);
		repeat (4) @(posedge clk);
		rd_reg(STAT_ADDR, 8'h08, 8'h88);
		sel <= 1'b0;
		$display("test abort done");
		wr_reg(CTRL_ADDR, 8'h53);
		wr_reg(STAT_ADDR, 8'h01);
		ss_n <= 1'b0;
		repeat (8) @(posedge clk);
		check("irq mode fault", {7'h00, irq}, 8'h01);
		ss_n <= 1'b1;
		repeat (4) @(posedge clk);
		check("pins released", {5'h00, sck_oe, mosi_oe, miso_oe}, 8'h00);
		rd_reg(CTRL_ADDR, 8'h00, 8'h40);
		rd_reg(STAT_ADDR, 8'h19, 8'hff);
		rd_reg(STAT_ADDR, 8'h09, 8'hff);
		repeat (3) @(posedge clk);
		check("irq after clear", {7'h00, irq}, 8'h00);
		$display("test mode fault done");
		finish_test();
	end
endmodule : testbench

`default_nettype wire
